// ===== logic/led_gpio_pad_mux.sv
/*
 * Pad control and multiplexing for eight shared pins: each is a port
 * status indicator or a general-purpose I/O, set over APB.
 * Assumes pad inputs are asynchronous and the PHY status is on clk.
 */
`timescale 1ns/1ps
module led_gpio_pad_mux (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire pad_mux_pkg::port_status_type  port1_status,
   input  wire pad_mux_pkg::port_status_type  port2_status,
   input  wire logic [7:0]                    pad_in,
   output logic      [7:0]                    pad_out,
   output logic      [7:0]                    pad_oe_n,
   output logic      [7:0]                    pad_pull_up_en,
   output logic      [7:0]                    pad_in_en
);

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0]               od_q;
   logic [7:0]               dir_out_q;
   logic [7:0]               data_q;
   logic [7:0]               ind_en_q;
   pad_mux_pkg::ind_sel_type ind_sel_q;
   logic [7:0]               in_meta_q;
   logic [7:0]               in_sync_q;
   logic [7:0]               port1_status_indicator;
   logic [7:0]               port2_status_indicator;
   pad_mux_pkg::pad_ctrl_type pad_q [8];

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic rd_wait_q;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] base);
      return a == base;
   endfunction : hit

   assign addr_ok = hit(paddr, pad_mux_pkg::GPIO_CFG_ADDR)
                  | hit(paddr, pad_mux_pkg::GPIO_DATA_ADDR)
                  | hit(paddr, pad_mux_pkg::IND_CFG_ADDR)
                  | hit(paddr, pad_mux_pkg::PAD_STAT_ADDR);
   assign wr_en   = psel & penable & pwrite & addr_ok;
   // Reads take one wait state so the registered read data stands
   // at the edge where pready is sampled high
   assign rd_en   = psel & penable & ~pwrite & ~rd_wait_q;
   assign pready  = pwrite | rd_wait_q;
   assign pslverr = psel & penable & pready & ~addr_ok;

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_wait_q <= 1'b0;
      end else begin
         rd_wait_q <= psel & penable & ~pwrite & ~rd_wait_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         od_q      <= pad_mux_pkg::GPIO_CFG_RST[7:0];
         dir_out_q <= pad_mux_pkg::GPIO_CFG_RST[15:8];
      end else if (wr_en && hit(paddr, pad_mux_pkg::GPIO_CFG_ADDR)) begin
         od_q      <= pwdata[pad_mux_pkg::GPIO_OD_LSB +: 8];
         dir_out_q <= pwdata[pad_mux_pkg::GPIO_DIR_LSB +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         data_q <= pad_mux_pkg::GPIO_DATA_RST[7:0];
      end else if (wr_en && hit(paddr, pad_mux_pkg::GPIO_DATA_ADDR)) begin
         data_q <= pwdata[pad_mux_pkg::GPIO_DATA_LSB +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ind_en_q  <= pad_mux_pkg::IND_CFG_RST[7:0];
         ind_sel_q <= pad_mux_pkg::ind_sel_type'(
                         pad_mux_pkg::IND_CFG_RST[9:8]);
      end else if (wr_en && hit(paddr, pad_mux_pkg::IND_CFG_ADDR)) begin
         ind_en_q  <= pwdata[pad_mux_pkg::IND_EN_LSB +: 8];
         ind_sel_q <= pad_mux_pkg::ind_sel_type'(
            pwdata[pad_mux_pkg::IND_SEL_MSB:pad_mux_pkg::IND_SEL_LSB]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= 32'h0000_0000;
         if (hit(paddr, pad_mux_pkg::GPIO_CFG_ADDR)) begin
            prdata[15:0] <= {dir_out_q, od_q};
         end else if (hit(paddr, pad_mux_pkg::GPIO_DATA_ADDR)) begin
            prdata[7:0] <= data_q;
         end else if (hit(paddr, pad_mux_pkg::IND_CFG_ADDR)) begin
            prdata[9:0] <= {ind_sel_q, ind_en_q};
         end else if (hit(paddr, pad_mux_pkg::PAD_STAT_ADDR)) begin
            prdata[15:0] <= {ind_en_q, in_sync_q};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchroniser

   always_ff @(posedge clk) begin
      if (rst) begin
         in_meta_q <= 8'h00;
         in_sync_q <= 8'h00;
      end else begin
         in_meta_q <= pad_in;
         // Receivers that are switched off read as zero
         in_sync_q <= in_meta_q & pad_in_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicator function select, low bits of each port map to pins 0-3/4-7

   function automatic logic ind_value(
      input pad_mux_pkg::port_status_type s,
      input pad_mux_pkg::ind_sel_type sel,
      input int unsigned idx);
      logic v;
      v = 1'b0;
      case (sel)
         pad_mux_pkg::IND_LINK_ACT:
            v = (idx == 0) ? (s.link | s.activity) :
                (idx == 1) ? s.speed100 :
                (idx == 2) ? s.full_duplex : s.collision;
         pad_mux_pkg::IND_SPEED:
            v = (idx[0]) ? s.speed100 : s.link;
         pad_mux_pkg::IND_DUPLEX:
            v = (idx[0]) ? s.full_duplex : s.activity;
         pad_mux_pkg::IND_LINK:
            v = s.link;
         default:
            v = 1'b0;
      endcase
      return v;
   endfunction : ind_value

   ////////////////////////////////////////////////////////////////////////
   // Pad control

   generate
      for (genvar i = 0; i < 4; i++) begin : g_ind
         assign port1_status_indicator[i] =
            ind_value(port1_status, ind_sel_q, i);
         assign port2_status_indicator[i+4] =
            ind_value(port2_status, ind_sel_q, i);
         assign port1_status_indicator[i+4] = 1'b0;
         assign port2_status_indicator[i]   = 1'b0;
      end

      for (genvar i = 0; i < 8; i++) begin : g_pad
         always_ff @(posedge clk) begin
            if (rst) begin
               pad_q[i] <= '{out: 1'b1, oe_n: 1'b1,
                            pull_up_en: 1'b1, in_en: 1'b1};
            end else if (ind_en_q[i]) begin
               // Pull low to light; release otherwise
               pad_q[i].out        <= 1'b0;
               pad_q[i].oe_n       <= ~(port1_status_indicator[i]
                                       | port2_status_indicator[i]);
               pad_q[i].pull_up_en <= 1'b0;
               pad_q[i].in_en      <= 1'b0;
            end else begin
               pad_q[i].pull_up_en <= 1'b1;
               pad_q[i].in_en      <= ~dir_out_q[i];
               if (!dir_out_q[i]) begin
                  pad_q[i].out  <= 1'b1;
                  pad_q[i].oe_n <= 1'b1;
               end else if (od_q[i]) begin
                  pad_q[i].out  <= 1'b0;
                  pad_q[i].oe_n <= data_q[i];
               end else begin
                  pad_q[i].out  <= data_q[i];
                  pad_q[i].oe_n <= 1'b0;
               end
            end
         end
         assign pad_out[i]        = pad_q[i].out;
         assign pad_oe_n[i]       = pad_q[i].oe_n;
         assign pad_pull_up_en[i] = pad_q[i].pull_up_en;
         assign pad_in_en[i]      = pad_q[i].in_en;
      end
   endgenerate

endmodule : led_gpio_pad_mux

// ===== logic/pad_mux_pkg.sv
/*
 * Constants and types for the shared indicator / general-purpose pad mux.
 * Assumes a single 100 MHz clock and an APB master with 32-bit data.
 */
// Functional notes
// - Indicator pins drive open-drain, active low.
// - Indicator pins have pull-up off and input receiver off.
// - Indicator function for all pins chosen by config bits 9:8.
// - GPIO pins: push-pull out, open-drain out, or Schmitt input.
// - Pull-up is on for every pin in GPIO use.
// - Input receiver off for GPIO pins set as output.
// - Only pins 0-7 may be indicators; 0-3 port 1, 4-7 port 2.
package pad_mux_pkg;

   localparam int unsigned NUM_PINS = 8;

   // Register byte addresses
   localparam logic [11:0] GPIO_CFG_ADDR   = 12'h0000;
   localparam logic [11:0] GPIO_DATA_ADDR  = 12'h0004;
   localparam logic [11:0] IND_CFG_ADDR    = 12'h0008;
   localparam logic [11:0] PAD_STAT_ADDR   = 12'h000C;

   // Field positions
   localparam int unsigned GPIO_OD_LSB     = 0;
   localparam int unsigned GPIO_DIR_LSB    = 8;
   localparam int unsigned GPIO_DATA_LSB   = 0;
   localparam int unsigned IND_EN_LSB      = 0;
   localparam int unsigned IND_SEL_LSB     = 8;
   localparam int unsigned IND_SEL_MSB     = 9;

   // Reset values
   localparam logic [31:0] GPIO_CFG_RST    = 32'h0000_0000;
   localparam logic [31:0] GPIO_DATA_RST   = 32'h0000_0000;
   localparam logic [31:0] IND_CFG_RST     = 32'h0000_0000;

   // Indicator function codes
   typedef enum logic [1:0] {
      IND_LINK_ACT,
      IND_SPEED,
      IND_DUPLEX,
      IND_LINK
   } ind_sel_type;

   // Per-port PHY status events feeding the indicators
   typedef struct packed {
      logic link;
      logic activity;
      logic speed100;
      logic full_duplex;
      logic collision;
   } port_status_type;

   // Pad control bundle for one pin
   typedef struct packed {
      logic out;
      logic oe_n;
      logic pull_up_en;
      logic in_en;
   } pad_ctrl_type;

endpackage : pad_mux_pkg

// ===== sim/pad_board_model.sv
/* Board side of the eight shared pads: LEDs and general-purpose signals.
   Assumes the pad controls of the mux; the bench sets the external drive. */
`timescale 1ns/1ps
module pad_board_model (
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe_n,
   input  wire logic [7:0] pad_pull_up_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad_level
);
   // Undriven pads without pull-up or external drive show the inverse of the last output
   assign pad_level = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
      | (pad_oe_n & ~ext_en & (pad_pull_up_en | ~pad_out));
endmodule : pad_board_model

// ===== sim/led_gpio_pad_mux_checker.sv
/* Concurrent checks on the ports of the pad mux.
   Assumes clk and a synchronous active-high rst. */
`timescale 1ns/1ps
module pad_mux_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe_n,
   input wire logic [7:0]  pad_pull_up_en,
   input wire logic [7:0]  pad_in_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_acc; psel && penable; endsequence
   sequence s_ind_wr;
      s_acc ##0 (pwrite && paddr == pad_mux_pkg::IND_CFG_ADDR);
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_PREADY: assert property (s_acc |-> ##[0:1] pready)
      else $error("pready low in access");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   AST_BAD_RD: assert property (s_acc ##0 (!pwrite && pslverr) |->
      prdata == 32'h0000_0000) else $error("unmapped read data");
   AST_RST_PADS: assert property ($fell(rst) |-> pad_oe_n == 8'hFF &&
      pad_pull_up_en == 8'hFF) else $error("pads after reset");
   AST_IND_RX: assert property ((~pad_pull_up_en & pad_in_en) == 8'h00)
      else $error("receiver on with pull-up off");
   AST_IND_OD: assert property ((~pad_pull_up_en & ~pad_oe_n & pad_out)
      == 8'h00) else $error("indicator drives high");
   AST_OUT_RX: assert property ((pad_pull_up_en & ~pad_oe_n & pad_in_en)
      == 8'h00) else $error("receiver on while driving");
   AST_IND_SEL: assert property (s_ind_wr ##0 pwdata[7:0] == 8'hFF
      |-> ##[1:2] pad_pull_up_en == 8'h00) else $error("indicator enable");
   AST_GPIO_PU: assert property (s_ind_wr ##0 pwdata[7:0] == 8'h00
      |-> ##[1:2] pad_pull_up_en == 8'hFF) else $error("gpio pull-up");
endmodule : pad_mux_checker
bind led_gpio_pad_mux pad_mux_checker pad_mux_checker_i (.clk(clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
   .pad_pull_up_en(pad_pull_up_en), .pad_in_en(pad_in_en));

// ===== sim/tb.sv
/* Directed testbench for the pad mux over APB.
   Assumes the board model resolves every pad level. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
 error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
   logic                         clk, rst, psel, penable, pwrite, e;
   logic                         pready, pslverr;
   logic [11:0]                  paddr;
   logic [31:0]                  pwdata, prdata, r;
   logic [7:0]                   pad_in, pad_out, pad_oe_n, pull, in_en;
   logic [7:0]                   ext_en, ext_val;
   pad_mux_pkg::port_status_type p1, p2;
   int                           error_cnt, samples_checked, cyc;
   led_gpio_pad_mux led_gpio_pad_mux_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port1_status(p1), .port2_status(p2), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up_en(pull),
      .pad_in_en(in_en));
   pad_board_model pad_board_model_i (.pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pad_pull_up_en(pull), .ext_en(ext_en),
      .ext_val(ext_val), .pad_level(pad_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1);
      e = pslverr;
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic t_gpio;
      apb(1'b1, pad_mux_pkg::GPIO_CFG_ADDR, 32'h0000_FFF0);
      apb(1'b1, pad_mux_pkg::GPIO_DATA_ADDR, 32'h0000_005A);
      repeat (3) @(posedge clk);
      `CHK("out", 4'hA, pad_out[3:0])
      `CHK("oe_n", 8'h50, pad_oe_n)
      `CHK("in_en", 8'h00, in_en)
      `CHK("pull", 8'hFF, pull)
      apb(1'b0, pad_mux_pkg::GPIO_DATA_ADDR, 32'h0000_0000);
      `CHK("data", 32'h0000_005A, r)
      apb(1'b1, pad_mux_pkg::GPIO_CFG_ADDR, 32'h0000_0000);
      ext_en <= 8'hFF;
      ext_val <= 8'hA5;
      repeat (4) @(posedge clk);
      apb(1'b0, pad_mux_pkg::PAD_STAT_ADDR, 32'h0000_0000);
      `CHK("stat", 32'h0000_00A5, r)
      `CHK("oe_n", 8'hFF, pad_oe_n)
      $display("test gpio done");
   endtask : t_gpio
   task automatic t_ind;
      logic [31:0] lit_tab;
      lit_tab = 32'h0FF0_0551;
      p1 <= 5'b10000;
      p2 <= 5'b01010;
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, pad_mux_pkg::IND_CFG_ADDR, 32'h0000_00FF | (s << 8));
         repeat (3) @(posedge clk);
         `CHK("lit", ~lit_tab[s*8 +: 8], pad_oe_n)
         `CHK("pu_rx", 16'h0000, {pull, in_en})
      end
      apb(1'b1, pad_mux_pkg::IND_CFG_ADDR, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK("err", 1'b1, e)
      `CHK("bad", 32'h0000_0000, r)
      $display("test indicator done");
   endtask : t_ind
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
      {p1, p2, ext_en, ext_val} = 26'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("rst_oe", 8'hFF, pad_oe_n)
      `CHK("rst_pu", 8'hFF, pull)
      t_gpio();
      t_ind();
      print_verdict();
   end
endmodule : tb
